//--- common/sme_if.sv
`timescale 1ns/1ns
`default_nettype none
// register port and interrupt pin between host and device
interface sme_if;
    logic       req;      // access request, held until ack
    logic       we;       // write when high
    logic [7:0] addr;     // register index
    logic [7:0] wdata;    // write data
    logic [7:0] rdata;    // read data, valid with ack
    logic       ack;      // one-cycle answer
    logic       int_pin;  // interrupt pin, active high

    modport dev (input req, we, addr, wdata, output rdata, ack, int_pin);
    modport hst (output req, we, addr, wdata, input rdata, ack, int_pin);
endinterface
`default_nettype wire

//--- common/sme_pkg.sv
// shared constants for the step and motion event logic and its host
package sme_pkg;

    // register indices on the device register port
    localparam logic [7:0] SME_OFF_SOURCE     = 8'h00; // step_event_source
    localparam logic [7:0] SME_OFF_STATUS     = 8'h01; // embedded_status
    localparam logic [7:0] SME_OFF_MIRROR     = 8'h02; // embedded_status_mirror
    localparam logic [7:0] SME_OFF_ENABLE     = 8'h03; // embedded_enable_first
    localparam logic [7:0] SME_OFF_EVT_ROUTE  = 8'h04; // embedded_interrupt_route
    localparam logic [7:0] SME_OFF_PIN_ROUTE  = 8'h05; // interrupt_pin_route
    localparam logic [7:0] SME_OFF_CONTROL    = 8'h06; // latch, timebase, wrap select, reinit
    localparam logic [7:0] SME_OFF_PERIOD_L   = 8'h07; // step_window_period low byte
    localparam logic [7:0] SME_OFF_PERIOD_H   = 8'h08; // step_window_period high byte
    localparam logic [7:0] SME_OFF_COUNT_L    = 8'h09; // step count low byte
    localparam logic [7:0] SME_OFF_COUNT_H    = 8'h0a; // step count high byte

    // step_event_source field positions
    localparam int SME_SRC_CLEAR   = 7; // step_count_clear
    localparam int SME_SRC_SEEN    = 5; // step seen after debounce
    localparam int SME_SRC_WINDOW  = 4; // window_step_flag
    localparam int SME_SRC_WRAP    = 3; // counter wrap flag
    localparam int SME_SRC_INC     = 2; // count_increment_flag

    // status, enable and route field positions (shared layout)
    localparam int SME_BIT_STEP    = 3; // step event / pedometer enable / step route
    localparam int SME_BIT_MOTION  = 5; // motion event / motion enable / motion route
    localparam int SME_PIN_EMB     = 1; // embedded_event_route

    // control register field positions
    localparam int SME_CTL_TIMEBASE = 0; // timebase enable
    localparam int SME_CTL_WRAPSEL  = 1; // wrap-report select
    localparam int SME_CTL_REINIT   = 2; // motion_detect_reinit, self clearing
    localparam int SME_CTL_LATCH    = 7; // embedded_event_latch

    // reset values
    localparam logic [7:0]  SME_RST_BYTE   = 8'h00;
    localparam logic [15:0] SME_RST_COUNT  = 16'h0000;

    // timing: clock, embedded tick and window unit
    localparam int SME_CLK_NS        = 20;
    localparam int SME_TICK_NS       = 40_000_000; // one period of the 25 Hz tick
    localparam int SME_UNIT_NS       = 2_560_000;  // 2.56 ms window unit
    localparam int SME_TICK_CYCLES   = SME_TICK_NS / SME_CLK_NS;
    localparam int SME_UNIT_CYCLES   = SME_UNIT_NS / SME_CLK_NS;

    // step thresholds
    localparam int SME_DEBOUNCE_STEPS = 10; // default debounce
    localparam int SME_MOTION_STEPS   = 10; // event when more than this

    // host apb register offsets
    localparam logic [7:0] SME_APB_CMD    = 8'h00; // [7:0] addr [15:8] data [16] write
    localparam logic [7:0] SME_APB_STAT   = 8'h04; // [0] busy [15:8] read data [16] pin
    localparam logic [7:0] SME_APB_SETUP  = 8'h08; // [0] start setup sequence
    localparam int         SME_SETUP_LEN  = 5;

endpackage

//--- dv/sme_props.sv
`timescale 1ns/1ns
`default_nettype none
// handshake and pin checks on the register port
module sme_props (
    // clock and reset
    input wire logic       clk_i,
    input wire logic       resetn_i,
    // port signals
    input wire logic       req,
    input wire logic       we,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic [7:0] rdata,
    input wire logic       ack,
    input wire logic       int_pin
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i);
    sequence taken_s; req && !ack; endsequence
    sequence held_s; req && $stable(addr) && $stable(we) && $stable(wdata); endsequence
    ack_pulse_a: assert property (ack |=> !ack) else $error("ack too long");
    ack_latency_a: assert property (taken_s |=> ack) else $error("ack late");
    req_hold_a: assert property (taken_s |=> held_s) else $error("request changed");
    ack_cause_a: assert property (ack |-> $past(req)) else $error("ack without request");
    req_release_a: assert property (ack |=> !req) else $error("request kept");
    write_keep_a: assert property (ack && we |=> $stable(rdata)) else $error("rdata moved");
    rdata_hold_a: assert property (!(req && !we) |=> $stable(rdata)) else $error("rdata lost");
    pin_width_a: assert property ($rose(int_pin) |-> int_pin [*8]) else $error("short pulse");
endmodule // sme_props
`default_nettype wire

//--- dv/test_step_and_motion_event_logic.sv
`timescale 1ns/1ns
`default_nettype none
module test_step_and_motion_event_logic;
    import sme_pkg::*;
    localparam int TK = 20; // shortened tick, keeps the run short
    logic        clk_i = 1'b0, resetn_i = 1'b0, psel = 1'b0, penable = 1'b0;
    logic        pwrite = 1'b0, step_i = 1'b0, pready, pslverr, tick_o, hit, seen;
    logic [31:0] paddr = '0, pwdata = '0, prdata, rd;
    logic [15:0] step_count_o;
    int          bad_count = 0, num_checks = 0, cyc = 0, n;
    sme_if b ();
    sme_device #(.TICK_CYCLES(TK), .UNIT_CYCLES(4)) sme_device_inst (.clk_i(clk_i),
        .resetn_i(resetn_i), .bus(b.dev), .step_i(step_i), .step_count_o(step_count_o),
        .tick_o(tick_o));
    sme_host sme_host_inst (.clk_i(clk_i), .resetn_i(resetn_i), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .bus(b.hst));
    sme_props sme_props_inst (.clk_i(clk_i), .resetn_i(resetn_i), .req(b.req), .we(b.we),
        .addr(b.addr), .wdata(b.wdata), .rdata(b.rdata), .ack(b.ack), .int_pin(b.int_pin));
    initial forever #10 clk_i = ~clk_i;
    // hang guard
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            bad_count++;
            stop_test();
        end
    end
    task automatic stop_test();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic check(input logic [31:0] s, input logic [31:0] e);
        num_checks++;
        if (s !== e) begin
            bad_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, s, e);
        end
    endtask
    // one apb transfer, held until pready
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {24'h0, a};
        pwdata <= d;
        @(posedge clk_i);
        penable <= 1'b1;
        do @(posedge clk_i); while (pready !== 1'b1);
        rd = prdata;
        hit = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_i);
    endtask
    // issue and poll busy until done
    task automatic dev(input logic [7:0] off, input logic [31:0] w);
        apb(1'b1, off, w);
        n = 0;
        do begin
            apb(1'b0, SME_APB_STAT, 32'h0);
            n++;
        end while (rd[0] !== 1'b0 && n < 50);
        rd = {24'h0, rd[15:8]};
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        dev(SME_APB_CMD, {15'h0, 1'b1, d, a});
    endtask
    task automatic rdv(input logic [7:0] a);
        dev(SME_APB_CMD, {24'h0, a});
    endtask
    task automatic steps(input int k);
        repeat (k) begin
            step_i <= 1'b1;
            @(posedge clk_i);
            step_i <= 1'b0;
            repeat (2) @(posedge clk_i);
        end
    endtask
    // pin sampled mid-cycle, away from the updating edge
    task automatic watch(input int k);
        seen = 1'b0;
        repeat (k) begin
            @(negedge clk_i);
            seen = seen | (b.int_pin === 1'b1);
        end
        @(posedge clk_i);
    endtask
    task automatic wait_hi();
        n = 0;
        while (b.int_pin !== 1'b1 && n < 200) begin
            @(negedge clk_i);
            n++;
        end
    endtask
    initial begin
        repeat (6) @(posedge clk_i);
        resetn_i <= 1'b1;
        @(posedge clk_i);
        rdv(SME_OFF_COUNT_L);
        check(rd, 32'h0);
        apb(1'b0, 8'h0c, 32'h0);
        check({31'h0, hit}, 32'h1);
        dev(SME_APB_SETUP, 32'h1);
        steps(9);
        rdv(SME_OFF_COUNT_L);
        check(rd, 32'h0);
        steps(1);
        rdv(SME_OFF_SOURCE);
        check(rd, 32'h24);
        check({16'h0, step_count_o}, 32'h1);
        watch(3 * TK);
        steps(1);
        wait_hi();
        n = 0;
        while (b.int_pin === 1'b1 && n < 100) begin
            @(negedge clk_i);
            n++;
        end
        check(n, TK);
        @(posedge clk_i);
        wr(SME_OFF_PIN_ROUTE, 8'h00);
        steps(1);
        watch(3 * TK);
        check({31'h0, seen}, 32'h0);
        wr(SME_OFF_PIN_ROUTE, 8'h02);
        wr(SME_OFF_CONTROL, 8'h81);
        for (int i = 0; i < 2; i++) begin
            steps(1);
            wait_hi();
            watch(3 * TK);
            check({31'h0, b.int_pin}, 32'h1);
            rdv(i == 0 ? SME_OFF_STATUS : SME_OFF_MIRROR);
            check(rd, 32'h08);
            watch(3);
            check({31'h0, b.int_pin}, 32'h0);
        end
        wr(SME_OFF_PERIOD_L, 8'h02);
        rdv(SME_OFF_SOURCE);
        steps(1);
        watch(20);
        rdv(SME_OFF_SOURCE);
        check(rd, 32'h30);
        watch(30);
        rdv(SME_OFF_SOURCE);
        check(rd, 32'h00);
        wr(SME_OFF_PERIOD_L, 8'h00);
        steps(1);
        watch(20);
        rdv(SME_OFF_SOURCE);
        check(rd, 32'h24);
        wr(SME_OFF_CONTROL, 8'h03);
        watch(TK);
        steps(1);
        watch(3 * TK);
        check({31'h0, seen}, 32'h0);
        wr(SME_OFF_SOURCE, 8'h80);
        rdv(SME_OFF_SOURCE);
        check(rd & 32'h80, 32'h0);
        check({16'h0, step_count_o}, 32'h0);
        wr(SME_OFF_ENABLE, 8'h20);
        wr(SME_OFF_EVT_ROUTE, 8'h20);
        for (int i = 0; i < 3; i++) begin
            if (i == 2) wr(SME_OFF_CONTROL, 8'h87);
            steps(10);
            watch(3 * TK);
            check({31'h0, seen}, 32'h0);
            if (i != 1) begin
                steps(1);
                wait_hi();
                check({31'h0, b.int_pin}, 32'h1);
                watch(8);
                rdv(SME_OFF_STATUS);
                check(rd, 32'h20);
            end
        end
        check({16'h0, step_count_o}, 32'h20);
        stop_test();
    end
endmodule // test_step_and_motion_event_logic
`default_nettype wire

//--- rtl/sme_device.sv
`timescale 1ns/1ns
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// - count clear bit zeroes count, self-clears
// - step seen flag after debounce only
// - window period is 16-bit, 2.56 ms units
// - window flag at period end if stepped
// - zero period holds window flag low
// - host enables timebase for window timer
// - wrap flag when count reaches 2^16
// - increment flag per step, zero with period
// - step event selects wrap, increment or window
// - step event in status and mirror
// - step to pin needs both route bits
// - embedded interrupt pulses one tick
// - latch holds until status bit read
// - motion event after more than ten steps
// - motion detector restarts after event
// - motion enable activates, reinit clears detector
// - motion enable also runs step counting
// - motion to pin needs both route bits
// - motion event pulsed, in status and mirror
// - host runs the enable sequence
// - step count is 16-bit high/low bytes
// - count starts at the tenth step, gaps allowed
module sme_device
    import sme_pkg::*;
#(
    parameter int TICK_CYCLES = SME_TICK_CYCLES,
    parameter int UNIT_CYCLES = SME_UNIT_CYCLES,
    parameter int DEB_STEPS   = SME_DEBOUNCE_STEPS
) (
    // clock and reset
    input  wire logic clk_i,
    input  wire logic resetn_i,
    // register port and pin
    sme_if.dev        bus,
    // raw step detector output
    input  wire logic step_i,
    // observation of internal state
    output logic [15:0] step_count_o,
    output logic        tick_o
);
    ////////////////////////////////////////////////////////////////////////////
    // registers
    logic [15:0] count_q;            // step count
    logic [15:0] period_q;           // step_window_period
    logic [7:0]  enable_q;           // embedded_enable_first
    logic [7:0]  evt_route_q;        // embedded_interrupt_route
    logic [7:0]  pin_route_q;        // interrupt_pin_route
    logic [7:0]  control_q;          // latch, timebase, wrap select, reinit
    logic        clear_q;            // step_count_clear pending
    logic        seen_q, win_q, wrap_q, inc_q; // source flags
    logic        stepped_q;          // debounced step within window
    logic [7:0]  deb_q;              // raw steps while counting enabled
    logic [7:0]  mot_q;              // steps since motion init
    logic        pend_step_q, pend_mot_q; // events waiting for the tick
    logic        stat_step_q, stat_mot_q; // embedded status bits
    logic [7:0]  rdata_q;
    logic        ack_q;
    logic        int_q;

    ////////////////////////////////////////////////////////////////////////////
    // access decode
    logic access, wr, rd;
    logic wr_src, wr_en, wr_evt, wr_pin, wr_ctl, wr_pl, wr_ph;
    logic rd_src, rd_stat;
    assign access  = bus.req && !ack_q;  // one answer per request
    assign wr      = access && bus.we;
    assign rd      = access && !bus.we;
    assign wr_src  = wr && (bus.addr == SME_OFF_SOURCE);
    assign wr_en   = wr && (bus.addr == SME_OFF_ENABLE);
    assign wr_evt  = wr && (bus.addr == SME_OFF_EVT_ROUTE);
    assign wr_pin  = wr && (bus.addr == SME_OFF_PIN_ROUTE);
    assign wr_ctl  = wr && (bus.addr == SME_OFF_CONTROL);
    assign wr_pl   = wr && (bus.addr == SME_OFF_PERIOD_L);
    assign wr_ph   = wr && (bus.addr == SME_OFF_PERIOD_H);
    assign rd_src  = rd && (bus.addr == SME_OFF_SOURCE);
    // both the status page and its mirror clear latched bits
    assign rd_stat = rd && (bus.addr == SME_OFF_STATUS
                         || bus.addr == SME_OFF_MIRROR);

    ////////////////////////////////////////////////////////////////////////////
    // step qualification
    logic period_zero, count_en, latch, deb_ok, dstep, unit_tick, win_end;
    logic wrap_set, inc_set, win_set, step_ev, mot_ev, mot_en;
    assign period_zero = (period_q == 16'h0000);
    assign mot_en      = enable_q[SME_BIT_MOTION];
    // motion detection needs the counter even if pedometer is off
    assign count_en    = enable_q[SME_BIT_STEP] || mot_en;
    assign latch       = control_q[SME_CTL_LATCH];
    assign deb_ok      = (deb_q >= 8'(DEB_STEPS - 1));
    assign dstep       = step_i && count_en && deb_ok;
    assign wrap_set    = dstep && (count_q == 16'hffff);
    assign inc_set     = dstep && period_zero;
    assign win_set     = win_end && (stepped_q || dstep);
    // source selection for the step event
    assign step_ev     = control_q[SME_CTL_WRAPSEL] ? wrap_set
                       : (period_zero ? inc_set : win_set);
    assign mot_ev      = mot_en && dstep
                      && (mot_q >= 8'(SME_MOTION_STEPS));

    ////////////////////////////////////////////////////////////////////////////
    // timers: 25 Hz tick, 2.56 ms unit, window period in units
    logic win_run;
    assign win_run = control_q[SME_CTL_TIMEBASE] && !period_zero;

    sme_pulse_timer #(.W(32)) u_tick (
        .clk_i     (clk_i),
        .resetn_i  (resetn_i),
        .run_i     (1'b1),
        .restart_i (1'b0),
        .en_i      (1'b1),
        .limit_i   (32'(TICK_CYCLES)),
        .tick_o    (tick_o)
    );

    // unit prescaler restarts with the window so units line up
    sme_pulse_timer #(.W(32)) u_unit (
        .clk_i     (clk_i),
        .resetn_i  (resetn_i),
        .run_i     (win_run),
        .restart_i (wr_pl || wr_ph || win_end),
        .en_i      (1'b1),
        .limit_i   (32'(UNIT_CYCLES)),
        .tick_o    (unit_tick)
    );

    sme_pulse_timer #(.W(16)) u_window (
        .clk_i     (clk_i),
        .resetn_i  (resetn_i),
        .run_i     (win_run),
        .restart_i (wr_pl || wr_ph),
        .en_i      (unit_tick),
        .limit_i   (period_q),
        .tick_o    (win_end)
    );

    ////////////////////////////////////////////////////////////////////////////
    // configuration registers
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            enable_q    <= SME_RST_BYTE;
            evt_route_q <= SME_RST_BYTE;
            pin_route_q <= SME_RST_BYTE;
            control_q   <= SME_RST_BYTE;
            period_q    <= SME_RST_COUNT;
        end else begin
            if (wr_en) enable_q <= bus.wdata;
            if (wr_evt) evt_route_q <= bus.wdata;
            if (wr_pin) pin_route_q <= bus.wdata;
            if (wr_ctl) begin
                control_q <= bus.wdata;
            end else begin
                control_q[SME_CTL_REINIT] <= 1'b0; // reinit self clears
            end
            if (wr_pl) period_q[7:0] <= bus.wdata;
            if (wr_ph) period_q[15:8] <= bus.wdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // counters: step count, debounce, motion progress
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            count_q <= SME_RST_COUNT;
            clear_q <= 1'b0;
            deb_q   <= SME_RST_BYTE;
            mot_q   <= SME_RST_BYTE;
        end else begin
            clear_q <= wr_src && bus.wdata[SME_SRC_CLEAR];
            if (clear_q) begin
                count_q <= SME_RST_COUNT;
            end else if (dstep) begin
                count_q <= count_q + 16'h0001;
            end
            if (step_i && count_en && !deb_ok) deb_q <= deb_q + 8'h01;
            // reinit, event or disable restart the motion detector
            if (control_q[SME_CTL_REINIT] || mot_ev || !mot_en) begin
                mot_q <= SME_RST_BYTE;
            end else if (dstep) begin
                mot_q <= mot_q + 8'h01;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // source flags: set wins over clear on read
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            seen_q    <= 1'b0;
            win_q     <= 1'b0;
            wrap_q    <= 1'b0;
            inc_q     <= 1'b0;
            stepped_q <= 1'b0;
        end else begin
            seen_q    <= dstep || (seen_q && !rd_src);
            win_q     <= !period_zero && (win_set || (win_q && !rd_src));
            wrap_q    <= wrap_set || (wrap_q && !rd_src);
            inc_q     <= !period_zero ? 1'b0
                       : (inc_set || (inc_q && !rd_src));
            stepped_q <= !win_end && (stepped_q || dstep);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // embedded status: events surface at the tick, last one tick or until read
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pend_step_q <= 1'b0;
            pend_mot_q  <= 1'b0;
            stat_step_q <= 1'b0;
            stat_mot_q  <= 1'b0;
        end else begin
            pend_step_q <= step_ev || (pend_step_q && !tick_o);
            pend_mot_q  <= mot_ev || (pend_mot_q && !tick_o);
            if (tick_o) begin
                // a new event at the tick wins over the read clear
                stat_step_q <= pend_step_q || (latch && stat_step_q && !rd_stat);
                stat_mot_q  <= pend_mot_q || (latch && stat_mot_q && !rd_stat);
            end else if (rd_stat && latch) begin
                stat_step_q <= 1'b0;
                stat_mot_q  <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read mux and answer
    logic [7:0] src_val, stat_val, rd_val;
    assign src_val  = {clear_q, 1'b0, seen_q, win_q, wrap_q, inc_q, 2'b00};
    assign stat_val = 8'({stat_mot_q, 1'b0, stat_step_q, 3'b000});
    always_comb begin
        case (bus.addr)
            SME_OFF_SOURCE:    rd_val = src_val;
            SME_OFF_STATUS,
            SME_OFF_MIRROR:    rd_val = stat_val;
            SME_OFF_ENABLE:    rd_val = enable_q;
            SME_OFF_EVT_ROUTE: rd_val = evt_route_q;
            SME_OFF_PIN_ROUTE: rd_val = pin_route_q;
            SME_OFF_CONTROL:   rd_val = control_q;
            SME_OFF_PERIOD_L:  rd_val = period_q[7:0];
            SME_OFF_PERIOD_H:  rd_val = period_q[15:8];
            SME_OFF_COUNT_L:   rd_val = count_q[7:0];
            SME_OFF_COUNT_H:   rd_val = count_q[15:8];
            default:           rd_val = SME_RST_BYTE; // unmapped reads zero
        endcase
    end

    // pin routing needs the event route and the global route
    logic int_d;
    assign int_d = pin_route_q[SME_PIN_EMB]
                && ((evt_route_q[SME_BIT_STEP] && stat_step_q)
                 || (evt_route_q[SME_BIT_MOTION] && stat_mot_q));

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ack_q   <= 1'b0;
            rdata_q <= SME_RST_BYTE;
            int_q   <= 1'b0;
        end else begin
            ack_q   <= access;
            int_q   <= int_d;
            if (rd) rdata_q <= rd_val;
        end
    end

    assign bus.ack      = ack_q;
    assign bus.rdata    = rdata_q;
    assign bus.int_pin  = int_q;
    assign step_count_o = count_q;
endmodule // sme_device
`default_nettype wire

//--- rtl/sme_host.sv
`timescale 1ns/1ns
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// apb-controlled host end: single accesses and a canned setup sequence
module sme_host
    import sme_pkg::*;
(
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        resetn_i,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // device side
    sme_if.hst               bus
);
    typedef enum logic [1:0] {SME_IDLE, SME_REQ} sme_state_e;

    sme_state_e  state_q;
    logic        we_q;
    logic [7:0]  addr_q, wdata_q, rdata_q;
    logic [2:0]  seq_q;        // remaining setup steps
    logic        seq_run_q;    // setup sequence active
    logic [31:0] prdata_q;

    ////////////////////////////////////////////////////////////////////////////
    // setup sequence: enables, routes and timebase, one write each
    function automatic logic [15:0] setup_step(input logic [2:0] i);
        case (i)
            3'd4:    setup_step = {SME_OFF_ENABLE, 8'h08};    // pedometer on
            3'd3:    setup_step = {SME_OFF_EVT_ROUTE, 8'h08}; // step route
            3'd2:    setup_step = {SME_OFF_CONTROL, 8'h01};   // timebase on
            3'd1:    setup_step = {SME_OFF_PIN_ROUTE, 8'h02}; // global route
            default: setup_step = 16'h0000;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // apb decode: zero wait states
    logic acc, apb_wr, wr_cmd, wr_setup, idle, hit;
    logic [15:0] step_w;
    assign acc      = psel && penable;
    assign apb_wr   = acc && pwrite;
    assign idle     = (state_q == SME_IDLE) && !seq_run_q;
    // commands while busy are dropped; busy tells software to wait
    assign wr_cmd   = apb_wr && idle && (paddr[7:0] == SME_APB_CMD);
    assign wr_setup = apb_wr && idle && (paddr[7:0] == SME_APB_SETUP) && pwdata[0];
    assign hit      = (paddr[7:0] == SME_APB_CMD) || (paddr[7:0] == SME_APB_STAT)
                   || (paddr[7:0] == SME_APB_SETUP);
    assign step_w   = setup_step(seq_q);
    assign pready   = 1'b1;
    assign pslverr  = acc && !hit;
    assign prdata   = prdata_q;

    ////////////////////////////////////////////////////////////////////////////
    // access engine
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state_q   <= SME_IDLE;
            we_q      <= 1'b0;
            addr_q    <= SME_RST_BYTE;
            wdata_q   <= SME_RST_BYTE;
            rdata_q   <= SME_RST_BYTE;
            seq_q     <= 3'd0;
            seq_run_q <= 1'b0;
        end else begin
            case (state_q)
                SME_IDLE: begin
                    if (wr_cmd) begin
                        addr_q  <= pwdata[7:0];
                        wdata_q <= pwdata[15:8];
                        we_q    <= pwdata[16];
                        state_q <= SME_REQ;
                    end else if (wr_setup) begin
                        seq_run_q <= 1'b1;
                        seq_q     <= 3'(SME_SETUP_LEN - 1);
                    end else if (seq_run_q) begin
                        addr_q  <= step_w[15:8];
                        wdata_q <= step_w[7:0];
                        we_q    <= 1'b1;
                        seq_q   <= seq_q - 3'd1;
                        state_q <= SME_REQ;
                        if (seq_q == 3'd1) seq_run_q <= 1'b0;
                    end
                end
                SME_REQ: begin
                    // request stays up until the device answers
                    if (bus.ack) begin
                        if (!we_q) rdata_q <= bus.rdata;
                        state_q <= SME_IDLE;
                    end
                end
                default: state_q <= SME_IDLE;
            endcase
        end
    end

    // status read back
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            prdata_q <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            prdata_q <= (paddr[7:0] == SME_APB_STAT)
                      ? {15'h0000, bus.int_pin, rdata_q, 7'h00, !idle}
                      : 32'h0000_0000;
        end
    end

    assign bus.req   = (state_q == SME_REQ);
    assign bus.we    = we_q;
    assign bus.addr  = addr_q;
    assign bus.wdata = wdata_q;
endmodule // sme_host
`default_nettype wire

//--- rtl/sme_pulse_timer.sv
`timescale 1ns/1ns
`default_nettype none
// counts enabled cycles and pulses on reaching the limit
module sme_pulse_timer #(
    parameter int W = 24
) (
    // clock and reset
    input  wire logic         clk_i,
    input  wire logic         resetn_i,
    // control
    input  wire logic         run_i,
    input  wire logic         restart_i,
    input  wire logic         en_i,
    input  wire logic [W-1:0] limit_i,
    // result
    output logic              tick_o
);
    logic [W-1:0] cnt_q;   // elapsed enabled cycles
    logic [W-1:0] cnt_d;
    logic         last;    // final count of this period

    assign last   = en_i && (cnt_q == limit_i - W'(1));
    assign tick_o = run_i && last;
    // restart or stop resets the phase so period ends stay regular
    assign cnt_d  = (!run_i || restart_i || last) ? '0
                  : (en_i ? cnt_q + W'(1) : cnt_q);

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_d;
        end
    end
endmodule // sme_pulse_timer
`default_nettype wire
